// >>> lsmnt_map.svh
// Register offsets, field positions, reset values and timing counts for the noise timer block.
`ifndef LSMNT_MAP_SVH
`define LSMNT_MAP_SVH
`define LSMNT_ADDR_MASK_A 5'h0b
`define LSMNT_ADDR_MASK_B 5'h0c
`define LSMNT_ADDR_NOISE_THR 5'h0d
`define LSMNT_ADDR_NOISE_PRE 5'h0e
`define LSMNT_MASK_RESET 8'h00
`define LSMNT_NTHR_RESET 7'h00
`define LSMNT_NPRE_RESET 8'h00
`define LSMNT_NTHR_VALID 8'h7f
`define LSMNT_FLAG_NOISE_LIMIT 5
`define LSMNT_CLK_PERIOD_NS 20
`define LSMNT_TICK_NS 80
`define LSMNT_TICK_CYCLES (`LSMNT_TICK_NS / `LSMNT_CLK_PERIOD_NS)
`define LSMNT_TICK_LAST 2'h3
`define LSMNT_ZERO7 7'h00
`define LSMNT_ZERO8 8'h00
`endif

// >>> lsmnt_pkg.sv
// Types shared by the line state mask and noise timer block.
package lsmnt_pkg;
  // Receive line state as reported by the line state detector.
  typedef enum logic [3:0] {
    LSMNT_LS_QUIET = 4'h0,
    LSMNT_LS_HALT = 4'h1,
    LSMNT_LS_MASTER = 4'h2,
    LSMNT_LS_IDLE = 4'h3,
    LSMNT_LS_NOSIG = 4'h4,
    LSMNT_LS_NOISE = 4'h5,
    LSMNT_LS_ACTIVE = 4'h6,
    LSMNT_LS_UNKNOWN = 4'h7
  } lsmnt_line_type;

  // Control bus access carrier.
  typedef struct packed {
    logic cs;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } lsmnt_bus_type;

  // Noise counter snapshot carrier.
  typedef struct packed {
    logic [6:0] count;
    logic [7:0] prescale;
  } lsmnt_count_type;
endpackage

// >>> lsmnt_tick.sv
// Symbol pair period tick generator.
`timescale 1ns/100ps
`include "lsmnt_map.svh"
module lsmnt_tick
  import lsmnt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  output logic tick
);
  logic [1:0] phase;
  wire logic phase_last = (phase == `LSMNT_TICK_LAST);

  // ----------------------------------------------------------------
  // Divider
  // ----------------------------------------------------------------
  // One pulse every 80 ns, taken from the local 50 MHz clock.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      phase <= 2'h0;
      tick <= 1'b0;
    end
    else
    begin
      phase <= phase_last ? 2'h0 : phase + 2'h1;
      tick <= phase_last; // R19
    end
  end

  a_tick_period: assert property (@(posedge ref_clk) disable iff (!arst_n) // R19
    tick |=> !tick [*3] ##1 tick)
    else $error("tick period is not four cycles");
endmodule

// >>> lsmnt_core.sv
// Receive condition masking and noise duration timer with its control bus registers.
//
// Contract
// R01: Summary A set when masked A flag set.
// R02: Summary B set when masked B flag set.
// R03: Reset clears both mask registers.
// R04: Mask A bits map to A flags in order.
// R05: Mask B bits map to B flags in order.
// R06: Noise counter decrements every 80(prescale+1) ns.
// R07: Zero after ((P+1)N+P) ticks of noise.
// R08: Both zero in noisy state reloads both.
// R09: Quiet-type states hold both counters loaded.
// R10: Threshold write loads both counters.
// R11: Prescale zero reloads prescale, decrements counter.
// R12: Entering noisy state keeps counting, no reload.
// R13: Both zero sets noise limit flag.
// R14: Software should program 40h and F9h.
// R15: Noise threshold seven bits, D7 reads zero.
// R16: Prescale threshold full eight bits.
// R17: Flag stays until nonzero threshold write.
// R18: Reset zeroes counter, flag set after reset.
// R19: Counters advance on one 80 ns tick.
`timescale 1ns/100ps
`include "lsmnt_map.svh"
module lsmnt_core
  import lsmnt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire lsmnt_bus_type bus,
  input wire lsmnt_line_type line_state,
  input wire logic [7:0] receive_cond_flags_a_in,
  input wire logic [7:0] receive_cond_flags_b,
  output logic [7:0] rdata,
  output logic receive_summary_a,
  output logic receive_summary_b,
  output logic noise_limit_flag,
  output lsmnt_count_type noise_count
);
  // ----------------------------------------------------------------
  // Decoding
  // ----------------------------------------------------------------
  logic [7:0] receive_cond_mask_a;
  logic [7:0] receive_cond_mask_b;
  logic [6:0] noise_threshold;
  logic [7:0] noise_prescale_threshold;
  logic [6:0] noise_cnt;
  logic [7:0] pre_cnt;
  logic tick;

  // Matches a write strobe against one register offset.
  function automatic logic hit(input lsmnt_bus_type b, input logic [4:0] a);
    hit = b.cs && b.wr && (b.addr == a);
  endfunction

  wire logic wr_mask_a = hit(bus, `LSMNT_ADDR_MASK_A);
  wire logic wr_mask_b = hit(bus, `LSMNT_ADDR_MASK_B);
  wire logic wr_nthr = hit(bus, `LSMNT_ADDR_NOISE_THR);
  wire logic wr_npre = hit(bus, `LSMNT_ADDR_NOISE_PRE);
  wire logic wr_thr = wr_nthr || wr_npre;
  // Only a nonzero value landing in a threshold releases the sticky flag; bit 7 of a
  // noise threshold write is dropped, so on its own it does not count.
  wire logic wr_nonzero = (wr_nthr && (bus.wdata[6:0] != `LSMNT_ZERO7))
    || (wr_npre && (bus.wdata != `LSMNT_ZERO8)); // R17

  // Line state classes.
  wire logic quiet_type = (line_state == LSMNT_LS_HALT) || (line_state == LSMNT_LS_IDLE)
    || (line_state == LSMNT_LS_MASTER) || (line_state == LSMNT_LS_QUIET)
    || (line_state == LSMNT_LS_NOSIG);
  wire logic noisy_type = (line_state == LSMNT_LS_NOISE) || (line_state == LSMNT_LS_ACTIVE)
    || (line_state == LSMNT_LS_UNKNOWN);

  wire logic cnt_zero = (noise_cnt == `LSMNT_ZERO7);
  wire logic pre_zero = (pre_cnt == `LSMNT_ZERO8);
  wire logic both_zero = cnt_zero && pre_zero; // R13
  // Reload on write, on any quiet-type state, or on expiry at a tick while noisy.
  wire logic reload = wr_thr || quiet_type || (both_zero && noisy_type && tick); // R08 R09 R10
  // Entering a noisy state needs no special term: the counters just keep going.
  wire logic step = noisy_type && tick && !both_zero; // R12 R19
  wire logic pre_wrap = step && pre_zero; // R11

  // The threshold values that a write lands in the counters are the new ones.
  wire logic [6:0] next_nthr = wr_nthr ? bus.wdata[6:0] : noise_threshold; // R15
  wire logic [7:0] next_npre = wr_npre ? bus.wdata : noise_prescale_threshold; // R16

  wire logic [6:0] next_cnt = reload ? next_nthr
    : pre_wrap ? noise_cnt - 7'h01 : noise_cnt; // R06 R07 R11
  wire logic [7:0] next_pre = reload ? next_npre
    : pre_wrap ? noise_prescale_threshold
    : step ? pre_cnt - 8'h01 : pre_cnt; // R06 R11

  // Flag A with the noise limit bit driven by this block.
  wire logic [7:0] flags_a = {receive_cond_flags_a_in[7:6], noise_limit_flag,
    receive_cond_flags_a_in[4:0]};
  // Bitwise pairing: mask bit n gates flag bit n, D0 to D7.
  wire logic next_sum_a = |(flags_a & receive_cond_mask_a); // R01 R04
  wire logic next_sum_b = |(receive_cond_flags_b & receive_cond_mask_b); // R02 R05

  // A threshold write blocks the set when it meets an expiry; a nonzero write clears the flag.
  wire logic next_flag = (both_zero && !wr_thr) || (noise_limit_flag && !wr_nonzero); // R13 R17

  logic [7:0] next_rdata;
  always_comb
  begin
    case (bus.addr)
      `LSMNT_ADDR_MASK_A: next_rdata = receive_cond_mask_a;
      `LSMNT_ADDR_MASK_B: next_rdata = receive_cond_mask_b;
      `LSMNT_ADDR_NOISE_THR: next_rdata = {1'b0, noise_threshold}; // R15
      `LSMNT_ADDR_NOISE_PRE: next_rdata = noise_prescale_threshold; // R16
      default: next_rdata = `LSMNT_ZERO8;
    endcase
  end

  lsmnt_tick u_tick (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Masks start cleared so nothing interrupts until software opts in.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      receive_cond_mask_a <= `LSMNT_MASK_RESET; // R03
      receive_cond_mask_b <= `LSMNT_MASK_RESET; // R03
      noise_threshold <= `LSMNT_NTHR_RESET;
      noise_prescale_threshold <= `LSMNT_NPRE_RESET;
    end
    else
    begin
      if (wr_mask_a)
        receive_cond_mask_a <= bus.wdata;
      if (wr_mask_b)
        receive_cond_mask_b <= bus.wdata;
      noise_threshold <= next_nthr;
      noise_prescale_threshold <= next_npre;
    end
  end

  // Counters start at zero, so the limit flag reads set out of reset.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      noise_cnt <= `LSMNT_ZERO7; // R18
      pre_cnt <= `LSMNT_ZERO8;
      noise_limit_flag <= 1'b1; // R18
    end
    else
    begin
      noise_cnt <= next_cnt;
      pre_cnt <= next_pre;
      noise_limit_flag <= next_flag;
    end
  end

  // Outputs are registered; summaries lag flag changes by one cycle.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata <= `LSMNT_ZERO8;
      receive_summary_a <= 1'b0;
      receive_summary_b <= 1'b0;
      noise_count <= '0;
    end
    else
    begin
      rdata <= next_rdata;
      receive_summary_a <= next_sum_a;
      receive_summary_b <= next_sum_b;
      noise_count <= {noise_cnt, pre_cnt};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Expiry with no write to cancel it.
  sequence s_expire;
    both_zero && !wr_thr;
  endsequence
  // Expiry at a tick while the line is noisy, with no write in the way.
  sequence s_expire_tick;
    both_zero && noisy_type && tick && !wr_thr;
  endsequence
  // A prescale wrap that no reload overrides.
  sequence s_wrap;
    pre_wrap && !reload;
  endsequence
  // A plain prescale step: no wrap and no reload.
  sequence s_pre_step;
    step && !pre_zero && !reload;
  endsequence
  // A noisy state entered between ticks, with no write, must leave the counters alone.
  sequence s_enter_noisy;
    !noisy_type ##1 (noisy_type && !tick && !wr_thr);
  endsequence

  // Summary bits follow the masked flags one cycle later, in both directions.
  a_sum_a_gate: assert property (@(posedge ref_clk) disable iff (!arst_n) // R01
    |(flags_a & receive_cond_mask_a) |=> receive_summary_a)
    else $error("summary A missed");
  a_sum_a_clear: assert property (@(posedge ref_clk) disable iff (!arst_n) // R01
    !(|(flags_a & receive_cond_mask_a)) |=> !receive_summary_a)
    else $error("summary A without masked flag");
  a_sum_b_gate: assert property (@(posedge ref_clk) disable iff (!arst_n) // R02
    !(|(receive_cond_flags_b & receive_cond_mask_b)) |=> !receive_summary_b)
    else $error("summary B without masked flag");
  a_sum_b_set: assert property (@(posedge ref_clk) disable iff (!arst_n) // R02
    |(receive_cond_flags_b & receive_cond_mask_b) |=> receive_summary_b)
    else $error("summary B missed");
  // The noise limit flag is the D5 condition, so its mask bit alone must raise summary A.
  a_flag_bit5: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    noise_limit_flag && receive_cond_mask_a[`LSMNT_FLAG_NOISE_LIMIT] |=> receive_summary_a)
    else $error("noise limit flag not gated by its mask bit");

  // Masks change only by a write and take the written byte whole.
  a_mask_a_write: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    wr_mask_a |=> receive_cond_mask_a == $past(bus.wdata))
    else $error("mask A write lost");
  a_mask_b_write: assert property (@(posedge ref_clk) disable iff (!arst_n) // R05
    wr_mask_b |=> receive_cond_mask_b == $past(bus.wdata))
    else $error("mask B write lost");
  a_mask_a_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    !wr_mask_a |=> $stable(receive_cond_mask_a))
    else $error("mask A changed without a write");
  a_mask_b_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // R03
    !wr_mask_b |=> $stable(receive_cond_mask_b))
    else $error("mask B changed without a write");

  // Threshold registers keep only their defined bits and move only on a write.
  a_nthr_write: assert property (@(posedge ref_clk) disable iff (!arst_n) // R15
    wr_nthr |=> {1'b0, noise_threshold} == ($past(bus.wdata) & `LSMNT_NTHR_VALID))
    else $error("noise threshold write wrong");
  a_npre_write: assert property (@(posedge ref_clk) disable iff (!arst_n) // R16
    wr_npre |=> noise_prescale_threshold == $past(bus.wdata))
    else $error("prescale threshold write wrong");
  a_thr_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
    !wr_thr |=> $stable(noise_threshold) && $stable(noise_prescale_threshold))
    else $error("threshold changed without a write");

  // Read data shows the addressed register one cycle after the address.
  a_thr_bit7: assert property (@(posedge ref_clk) disable iff (!arst_n) // R15
    bus.addr == `LSMNT_ADDR_NOISE_THR |=> !rdata[7])
    else $error("threshold D7 not zero");
  a_read_mask_a: assert property (@(posedge ref_clk) disable iff (!arst_n) // R04
    bus.addr == `LSMNT_ADDR_MASK_A |=> rdata == $past(receive_cond_mask_a))
    else $error("mask A read back wrong");
  a_read_mask_b: assert property (@(posedge ref_clk) disable iff (!arst_n) // R05
    bus.addr == `LSMNT_ADDR_MASK_B |=> rdata == $past(receive_cond_mask_b))
    else $error("mask B read back wrong");
  a_read_npre: assert property (@(posedge ref_clk) disable iff (!arst_n) // R16
    bus.addr == `LSMNT_ADDR_NOISE_PRE |=> rdata == $past(noise_prescale_threshold))
    else $error("prescale threshold read back wrong");

  // Loading: quiet-type states and threshold writes put both thresholds in the counters.
  a_quiet_hold: assert property (@(posedge ref_clk) disable iff (!arst_n) // R09
    quiet_type && !wr_thr |=> noise_cnt == $past(noise_threshold)
      && pre_cnt == $past(noise_prescale_threshold))
    else $error("quiet state not loaded");
  a_write_load: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
    wr_npre |=> pre_cnt == noise_prescale_threshold && noise_cnt == noise_threshold)
    else $error("threshold write did not load");
  a_nthr_load: assert property (@(posedge ref_clk) disable iff (!arst_n) // R10
    wr_nthr |=> noise_cnt == noise_threshold && pre_cnt == noise_prescale_threshold)
    else $error("noise threshold write did not load");

  // Counting: the prescaler steps on each tick while the line is noisy and wraps into one main count.
  a_prescale_wrap: assert property (@(posedge ref_clk) disable iff (!arst_n) // R11
    s_wrap |=> noise_cnt == $past(noise_cnt) - 7'h01
      && pre_cnt == noise_prescale_threshold)
    else $error("prescale wrap wrong");
  a_pre_step: assert property (@(posedge ref_clk) disable iff (!arst_n) // R06
    s_pre_step |=> pre_cnt == $past(pre_cnt) - 8'h01 && $stable(noise_cnt))
    else $error("prescale step wrong");
  a_noisy_keep: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
    noisy_type && !tick && !wr_thr |=> $stable(noise_cnt) && $stable(pre_cnt))
    else $error("counter moved off tick");
  a_enter_keep: assert property (@(posedge ref_clk) disable iff (!arst_n) // R12
    s_enter_noisy |=> $stable(noise_cnt) && $stable(pre_cnt))
    else $error("entering a noisy state reloaded the counters");
  // Between ticks nothing but a reload may move the counters.
  a_tick_only: assert property (@(posedge ref_clk) disable iff (!arst_n) // R19
    !tick && !reload |=> $stable(noise_cnt) && $stable(pre_cnt))
    else $error("counters moved without a tick");

  // Expiry: zero counters wait for the next tick, then reload both together.
  a_reload_exp: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    both_zero && noisy_type && tick |=> noise_cnt == $past(next_nthr))
    else $error("expiry reload missed");
  a_reload_pre: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    s_expire_tick |=> pre_cnt == noise_prescale_threshold)
    else $error("expiry prescale reload missed");
  a_zero_wait: assert property (@(posedge ref_clk) disable iff (!arst_n) // R08
    both_zero && noisy_type && !tick && !wr_thr |=> both_zero)
    else $error("zero counters left before the tick");

  // Flag: set by expiry or by reset, cleared only by a nonzero threshold write.
  a_flag_set: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
    s_expire |=> noise_limit_flag)
    else $error("noise limit flag not set");
  a_flag_rise: assert property (@(posedge ref_clk) disable iff (!arst_n) // R13
    $rose(noise_limit_flag) |-> $past(both_zero))
    else $error("noise limit flag set without expiry");
  a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n) // R17
    noise_limit_flag && !wr_nonzero |=> noise_limit_flag)
    else $error("flag dropped");
  a_flag_clear: assert property (@(posedge ref_clk) disable iff (!arst_n) // R17
    wr_nonzero |=> !noise_limit_flag)
    else $error("nonzero threshold write left the flag set");

  // ----------------------------------------------------------------
  // Timing model
  // ----------------------------------------------------------------
  // Ticks still owed before both counters reach zero. Keeping this closed-form count
  // beside the counters checks the whole time to zero, not only each single step,
  // at the price of one 16-bit register that only the checks read.
  logic [15:0] owed_ticks;
  wire logic [15:0] pre_span = {8'h00, next_npre} + 16'h0001;
  wire logic [15:0] owed_load = pre_span * {9'h000, next_nthr} + {8'h00, next_npre}; // R07
  wire logic [15:0] next_owed = reload ? owed_load
    : step ? owed_ticks - 16'h0001 : owed_ticks; // R07

  // The model starts where the counters do: both zero, nothing owed.
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      owed_ticks <= 16'h0000;
    else
      owed_ticks <= next_owed;
  end

  a_zero_time: assert property (@(posedge ref_clk) disable iff (!arst_n) // R07
    both_zero == (owed_ticks == 16'h0000))
    else $error("time to zero differs from the closed form");
endmodule

// >>> lsmnt_mgmt.sv
// Management processor model that drives the control bus of the noise timer block.
`timescale 1ns/100ps
`include "lsmnt_map.svh"
module lsmnt_mgmt
  import lsmnt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic [7:0] rdata,
  output lsmnt_bus_type bus
);
  // The bus starts deselected.
  initial bus = '{cs: 1'b0, wr: 1'b0, addr: 5'h1f, wdata: 8'h00};
  // A write is held across one rising edge. Released lines show inverted data, never stale.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    bus = '{cs: 1'b1, wr: 1'b1, addr: a, wdata: d};
    @(negedge ref_clk);
    bus = '{cs: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // A read answers one edge after the address is held.
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    bus = '{cs: 1'b1, wr: 1'b0, addr: a, wdata: ~bus.wdata};
    @(negedge ref_clk);
    d = rdata;
    bus = '{cs: 1'b0, wr: 1'b0, addr: ~a, wdata: ~bus.wdata};
  endtask
  // Software programs the standard noise event limit this way.
  task automatic setup_std();
    wr(`LSMNT_ADDR_NOISE_THR, 8'h40);
    wr(`LSMNT_ADDR_NOISE_PRE, 8'hf9);
  endtask
endmodule

// >>> line_state_mask_noise_timer_test.sv
// Self-checking bench for the line state mask and noise timer block.
`timescale 1ns/100ps
`include "lsmnt_map.svh"
module line_state_mask_noise_timer_test
  import lsmnt_pkg::*;
;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  lsmnt_bus_type bus;
  lsmnt_line_type line_state = LSMNT_LS_QUIET;
  logic [7:0] flags_a = 8'h00;
  logic [7:0] flags_b = 8'h00;
  logic [7:0] rdata;
  logic sum_a;
  logic sum_b;
  logic nflag;
  lsmnt_count_type noise_count;
  logic [7:0] rv;
  int n_mismatch = 0;
  int comparisons = 0;
  int n;
  initial forever #10 ref_clk = ~ref_clk;
  lsmnt_mgmt mgmt (.ref_clk(ref_clk), .rdata(rdata), .bus(bus));
  lsmnt_core dut (.ref_clk(ref_clk), .arst_n(arst_n), .bus(bus), .line_state(line_state),
    .receive_cond_flags_a_in(flags_a), .receive_cond_flags_b(flags_b), .rdata(rdata),
    .receive_summary_a(sum_a), .receive_summary_b(sum_b), .noise_limit_flag(nflag),
    .noise_count(noise_count));
  // ------------------------------------------------------------
  // Checking helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [14:0] seen, input logic [14:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [7:0] exp);
    mgmt.rd(a, rv);
    chk("rdata", rv, exp);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // The whole run takes about two hundred cycles, so a hang is cut off well beyond that.
  initial
  begin
    #100us;
    n_mismatch++;
    summarize();
  end
  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial
  begin
    cyc(3);
    arst_n = 1'b1;
    chk("flag", nflag, 1'b1);
    chk("count", noise_count, 15'h0);
    rdchk(`LSMNT_ADDR_MASK_A, 8'h00);
    rdchk(`LSMNT_ADDR_MASK_B, 8'h00);
    flags_a = 8'hff;
    flags_b = 8'hff;
    cyc(2);
    chk("sum_a", sum_a, 1'b0);
    chk("sum_b", sum_b, 1'b0);
    $display("test reset done");
    // One mask bit at a time; bit 5 of A is the internal flag, still set from reset.
    for (int i = 0; i < 8; i++)
    begin
      mgmt.wr(`LSMNT_ADDR_MASK_A, 8'h01 << i);
      mgmt.wr(`LSMNT_ADDR_MASK_B, 8'h01 << i);
      rdchk(`LSMNT_ADDR_MASK_A, 8'h01 << i);
      flags_a = (i == 5) ? 8'h00 : 8'h01 << i;
      flags_b = 8'h01 << i;
      cyc(2);
      chk("sum_a", sum_a, 1'b1);
      chk("sum_b", sum_b, 1'b1);
      flags_a = ~(8'h01 << i);
      flags_b = ~(8'h01 << i);
      cyc(2);
      chk("sum_a", sum_a, i == 5);
      chk("sum_b", sum_b, 1'b0);
    end
    $display("test masks done");
    mgmt.wr(`LSMNT_ADDR_NOISE_THR, 8'hff);
    rdchk(`LSMNT_ADDR_NOISE_THR, 8'h7f);
    mgmt.wr(`LSMNT_ADDR_NOISE_PRE, 8'ha5);
    rdchk(`LSMNT_ADDR_NOISE_PRE, 8'ha5);
    rdchk(5'h1f, 8'h00);
    mgmt.setup_std();
    rdchk(`LSMNT_ADDR_NOISE_THR, 8'h40);
    chk("count", noise_count, {7'h40, 8'hf9});
    chk("flag", nflag, 1'b0);
    $display("test registers done");
    // Five ticks to zero with threshold 2 and prescale 1; state changes must not reload.
    mgmt.wr(`LSMNT_ADDR_NOISE_THR, 8'h02);
    mgmt.wr(`LSMNT_ADDR_NOISE_PRE, 8'h01);
    cyc(6);
    chk("count", noise_count, {7'h02, 8'h01});
    line_state = LSMNT_LS_NOISE;
    n = 0;
    while (nflag !== 1'b1 && n < 60)
    begin
      cyc(1);
      n++;
      if (n == 8)
        line_state = LSMNT_LS_ACTIVE;
      if (n == 14)
        line_state = LSMNT_LS_UNKNOWN;
    end
    chk("ticks", n >= 17 && n <= 22, 1'b1);
    cyc(6);
    chk("reload", noise_count.count, 7'h02);
    cyc(30);
    chk("flag", nflag, 1'b1);
    mgmt.wr(`LSMNT_ADDR_NOISE_PRE, 8'h20);
    cyc(1);
    chk("count", noise_count.count, 7'h02);
    chk("pre", noise_count.prescale > 8'h1d, 1'b1);
    chk("flag", nflag, 1'b0);
    $display("test noise timer done");
    // A second reset in mid-run must close masks that software had opened.
    flags_a = 8'hff;
    flags_b = 8'hff;
    cyc(2);
    chk("sum_a", sum_a, 1'b1);
    chk("sum_b", sum_b, 1'b1);
    arst_n = 1'b0;
    cyc(1);
    chk("flag", nflag, 1'b1);
    chk("count", noise_count, 15'h0);
    chk("sum_a", sum_a, 1'b0);
    chk("sum_b", sum_b, 1'b0);
    arst_n = 1'b1;
    rdchk(`LSMNT_ADDR_MASK_A, 8'h00);
    rdchk(`LSMNT_ADDR_MASK_B, 8'h00);
    chk("sum_a", sum_a, 1'b0);
    $display("test second reset done");
    summarize();
  end
endmodule
